// ### verilog/ict_pkg.sv
// Shared types and cycle counts for the instruction cycle timing block
package ict_pkg;

	// ==========================================================
	// Bus cycle classes
	typedef enum logic [1:0]
	{
		ICT_NSEQ = 2'h0,
		ICT_SEQ = 2'h1,
		ICT_INT = 2'h2,
		ICT_COPROC = 2'h3
	} ict_cyc_t;

	// ==========================================================
	// Instruction classes at issue
	typedef enum logic [3:0]
	{
		ICT_CL_DATAOP = 4'h0,
		ICT_CL_LZ_COUNT = 4'h1,
		ICT_CL_WORD_LOAD = 4'h2,
		ICT_CL_DWORD_LOAD = 4'h3,
		ICT_CL_WORD_STORE = 4'h4,
		ICT_CL_DWORD_STORE = 4'h5,
		ICT_CL_MULTI_LOAD = 4'h6,
		ICT_CL_MULTI_STORE = 4'h7,
		ICT_CL_SWAP = 4'h8,
		ICT_CL_PRELOAD = 4'h9,
		ICT_CL_BRANCH = 4'hA,
		ICT_CL_SOFT_INT = 4'hB,
		ICT_CL_UNDEF = 4'hC,
		ICT_CL_COPROC_DP = 4'hD
	} ict_class_t;

	// ==========================================================
	// Data bus patterns and sequencer states
	typedef enum logic [1:0]
	{
		ICT_DP_IDLE = 2'h0,
		ICT_DP_BURST = 2'h1,
		ICT_DP_SWAP = 2'h2
	} ict_dpat_t;

	typedef enum logic [1:0]
	{
		ICT_ST_IDLE = 2'b01,
		ICT_ST_RUN = 2'b10
	} ict_state_t;

	// ==========================================================
	// Cycle counts
	localparam logic [5:0] ICT_T_ONE = 6'h01;
	localparam logic [5:0] ICT_T_REG_SHIFT = 6'h02;
	localparam logic [5:0] ICT_T_PC_ARITH = 6'h03;
	localparam logic [5:0] ICT_T_PC_LOGIC = 6'h04;
	localparam logic [5:0] ICT_T_SHIFT_LOAD = 6'h02;
	localparam logic [5:0] ICT_T_NARROW_USE = 6'h03;
	localparam logic [5:0] ICT_T_LOAD_PC = 6'h05;
	localparam logic [5:0] ICT_T_LOAD_PC_SCALED = 6'h06;
	localparam logic [5:0] ICT_T_DUAL = 6'h02;
	localparam logic [5:0] ICT_T_MULTI_ONE = 6'h02;
	localparam logic [5:0] ICT_T_MULTI_PC_EXTRA = 6'h04;
	localparam logic [5:0] ICT_T_STORE_SCALED = 6'h02;
	localparam logic [5:0] ICT_T_SWAP = 6'h02;
	localparam logic [5:0] ICT_T_BRANCH = 6'h03;
	localparam logic [5:0] ICT_T_USE_STALL = 6'h01;
	localparam logic [5:0] ICT_T_NARROW_STALL = 6'h02;
	localparam logic [5:0] ICT_WORDS_DUAL = 6'h02;
	localparam logic [5:0] ICT_SWAP_ACCESSES = 6'h02;
	localparam logic [5:0] ICT_PCW_N_BACK = 6'h02;
	localparam logic [5:0] ICT_K_FIRST = 6'h00;

endpackage

// ### verilog/ict_hazard.sv
// Load-use comparison of a load destination against next sources
`timescale 1ns/1ps
module ict_hazard
	import ict_pkg::*;
(
	// Load destination
	input wire logic [3:0] dest,
	input wire logic dest_en,
	// Next instruction sources
	input wire logic [3:0] src_a,
	input wire logic [3:0] src_b,
	input wire logic [3:0] src_c,
	input wire logic [2:0] src_en,
	// Result
	output logic hit
);

	logic [3:0] srcs [3];
	logic [2:0] match;

	assign srcs[0] = src_a;
	assign srcs[1] = src_b;
	assign srcs[2] = src_c;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_cmp
			assign match[gi] = src_en[gi] && (srcs[gi] == dest);
		end
	endgenerate

	assign hit = dest_en && (|match);

endmodule

// ### verilog/ict_bus_type.sv
// Cycle class on each bus for one cycle of an instruction plan
`timescale 1ns/1ps
module ict_bus_type
	import ict_pkg::*;
(
	// Plan and position
	input wire logic [5:0] k,
	input wire logic [5:0] t,
	input wire logic pcw,
	input wire ict_dpat_t dpat,
	input wire logic [5:0] nb,
	input wire logic first_seq,
	// Cycle classes
	output ict_cyc_t icyc,
	output ict_cyc_t dcyc
);

	always_comb
	begin
		icyc = ICT_INT;
		if (k == ICT_K_FIRST)
			icyc = ICT_SEQ;
		else if (pcw && k == 6'(t - ICT_PCW_N_BACK))
			icyc = ICT_NSEQ;
		else if (pcw && k == 6'(t - ICT_T_ONE))
			icyc = ICT_SEQ;
	end

	always_comb
	begin
		dcyc = ICT_INT;
		unique case (dpat)
			ICT_DP_BURST:
			begin
				if (k == ICT_K_FIRST)
					dcyc = first_seq ? ICT_SEQ : ICT_NSEQ;
				else if (k < nb)
					dcyc = ICT_SEQ;
			end
			ICT_DP_SWAP:
			begin
				if (k < ICT_SWAP_ACCESSES)
					dcyc = ICT_NSEQ;
			end
			ICT_DP_IDLE:
				dcyc = ICT_INT;
			default:
				dcyc = ICT_INT;
		endcase
	end

endmodule

// ### verilog/ict_timing.sv
// Instruction cycle sequencer driving instruction and data bus cycle classes
`timescale 1ns/1ps
module ict_timing
	import ict_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Issued instruction
	input wire logic ISSUE_VALID,
	input wire ict_class_t ISSUE_CLASS,
	input wire logic ISSUE_PC_DEST,
	input wire logic ISSUE_REG_SHIFT,
	input wire logic ISSUE_SHIFTED,
	input wire logic ISSUE_ARITH,
	input wire logic ISSUE_NARROW,
	input wire logic [4:0] ISSUE_NREGS,
	input wire logic [3:0] ISSUE_LOAD_DEST,
	input wire logic [3:0] COPROC_WAIT,
	// Following instruction sources
	input wire logic NEXT_VALID,
	input wire logic [3:0] NEXT_SRC_A,
	input wire logic [3:0] NEXT_SRC_B,
	input wire logic [3:0] NEXT_SRC_C,
	input wire logic [2:0] NEXT_SRC_EN,
	// Sequencer status
	output logic ISSUE_READY,
	output logic INSTR_END,
	output logic INTERLOCK,
	output logic DATA_SPECULATIVE_FLAG,
	// Bus cycle classes
	output ict_cyc_t I_CYC,
	output ict_cyc_t D_CYC
);

	// ==========================================================
	// Hazard detection
	logic acc;
	logic ld_en;
	logic hit;
	logic dep;

	assign acc = ISSUE_VALID && ISSUE_READY;
	assign ld_en = !ISSUE_PC_DEST && (ISSUE_CLASS == ICT_CL_WORD_LOAD || ISSUE_CLASS == ICT_CL_DWORD_LOAD
		|| ISSUE_CLASS == ICT_CL_MULTI_LOAD || ISSUE_CLASS == ICT_CL_SWAP);

	ict_hazard u_hazard
	(
		.dest(ISSUE_LOAD_DEST),
		.dest_en(ld_en),
		.src_a(NEXT_SRC_A),
		.src_b(NEXT_SRC_B),
		.src_c(NEXT_SRC_C),
		.src_en(NEXT_SRC_EN),
		.hit(hit)
	);

	assign dep = hit && NEXT_VALID;

	// ==========================================================
	// Plan of a newly issued instruction
	logic [5:0] n_t;
	logic [5:0] n_nb;
	logic [5:0] n_ilk;
	logic [5:0] nr;
	logic n_pcw;
	logic n_fs;
	logic n_spec;
	ict_dpat_t n_dpat;

	assign nr = {1'b0, ISSUE_NREGS};

	always_comb
	begin
		n_t = ICT_T_ONE;
		n_nb = ICT_T_ONE;
		n_ilk = '0;
		n_pcw = 1'b0;
		n_fs = 1'b0;
		n_spec = 1'b0;
		n_dpat = ICT_DP_IDLE;
		unique case (ISSUE_CLASS)
			ICT_CL_DATAOP:
			begin
				if (ISSUE_PC_DEST)
				begin
					n_pcw = 1'b1;
					if (ISSUE_ARITH && !ISSUE_SHIFTED && !ISSUE_REG_SHIFT)
						n_t = ICT_T_PC_ARITH;
					else
						n_t = ICT_T_PC_LOGIC;
				end
				else if (ISSUE_REG_SHIFT)
					n_t = ICT_T_REG_SHIFT;
			end
			ICT_CL_LZ_COUNT:
				n_t = ICT_T_ONE;
			ICT_CL_WORD_LOAD:
			begin
				n_dpat = ICT_DP_BURST;
				if (ISSUE_PC_DEST)
				begin
					n_pcw = 1'b1;
					n_t = ISSUE_SHIFTED ? ICT_T_LOAD_PC_SCALED : ICT_T_LOAD_PC;
				end
				else if (dep && ISSUE_NARROW)
				begin
					n_t = ICT_T_NARROW_USE;
					n_ilk = ICT_T_NARROW_STALL;
				end
				else
				begin
					n_t = ISSUE_SHIFTED ? ICT_T_SHIFT_LOAD : ICT_T_ONE;
					if (dep)
					begin
						n_t = 6'(n_t + ICT_T_USE_STALL);
						n_ilk = ICT_T_USE_STALL;
					end
				end
			end
			ICT_CL_DWORD_LOAD:
			begin
				n_dpat = ICT_DP_BURST;
				n_nb = ICT_WORDS_DUAL;
				n_t = ICT_T_DUAL;
				if (dep)
				begin
					n_t = 6'(ICT_T_DUAL + ICT_T_USE_STALL);
					n_ilk = ICT_T_USE_STALL;
				end
			end
			ICT_CL_WORD_STORE:
			begin
				n_dpat = ICT_DP_BURST;
				n_t = ISSUE_SHIFTED ? ICT_T_STORE_SCALED : ICT_T_ONE;
			end
			ICT_CL_DWORD_STORE:
			begin
				n_dpat = ICT_DP_BURST;
				n_nb = ICT_WORDS_DUAL;
				n_t = ICT_T_DUAL;
			end
			ICT_CL_MULTI_LOAD:
			begin
				n_dpat = ICT_DP_BURST;
				n_nb = nr;
				if (ISSUE_PC_DEST)
				begin
					n_pcw = 1'b1;
					n_t = 6'(nr + ICT_T_MULTI_PC_EXTRA);
				end
				else if (nr == ICT_T_ONE)
				begin
					n_t = ICT_T_MULTI_ONE;
					n_fs = 1'b1;
				end
				else
				begin
					n_t = nr;
					if (dep)
					begin
						n_t = 6'(nr + ICT_T_USE_STALL);
						n_ilk = ICT_T_USE_STALL;
					end
				end
			end
			ICT_CL_MULTI_STORE:
			begin
				n_dpat = ICT_DP_BURST;
				n_nb = nr;
				n_t = (nr == ICT_T_ONE) ? ICT_T_MULTI_ONE : nr;
			end
			ICT_CL_SWAP:
			begin
				n_dpat = ICT_DP_SWAP;
				n_t = ICT_T_SWAP;
				if (dep)
				begin
					n_t = 6'(ICT_T_SWAP + ICT_T_USE_STALL);
					n_ilk = ICT_T_USE_STALL;
				end
			end
			ICT_CL_PRELOAD:
				n_spec = 1'b1;
			ICT_CL_BRANCH, ICT_CL_SOFT_INT, ICT_CL_UNDEF:
			begin
				n_pcw = 1'b1;
				n_t = ICT_T_BRANCH;
			end
			ICT_CL_COPROC_DP:
				n_t = 6'(ICT_T_ONE + {2'h0, COPROC_WAIT});
			default:
				n_t = ICT_T_ONE;
		endcase
	end

	// ==========================================================
	// Sequencer next state
	ict_state_t state_q;
	ict_state_t state_d;
	ict_dpat_t dpat_q;
	ict_dpat_t dpat_d;
	ict_cyc_t icyc_w;
	ict_cyc_t dcyc_w;
	logic [5:0] k_q;
	logic [5:0] k_d;
	logic [5:0] t_q;
	logic [5:0] t_d;
	logic [5:0] nb_q;
	logic [5:0] nb_d;
	logic [5:0] ilk_q;
	logic [5:0] ilk_d;
	logic pcw_q;
	logic pcw_d;
	logic fs_q;
	logic fs_d;
	logic spec_q;
	logic spec_d;
	logic run_d;
	logic end_d;

	always_comb
	begin
		state_d = ICT_ST_IDLE;
		k_d = ICT_K_FIRST;
		t_d = t_q;
		nb_d = nb_q;
		ilk_d = ilk_q;
		pcw_d = pcw_q;
		fs_d = fs_q;
		spec_d = spec_q;
		dpat_d = dpat_q;
		if (state_q == ICT_ST_RUN && !INSTR_END)
		begin
			state_d = ICT_ST_RUN;
			k_d = 6'(k_q + ICT_T_ONE);
		end
		else if (acc)
		begin
			state_d = ICT_ST_RUN;
			t_d = n_t;
			nb_d = n_nb;
			ilk_d = n_ilk;
			pcw_d = n_pcw;
			fs_d = n_fs;
			spec_d = n_spec;
			dpat_d = n_dpat;
		end
	end

	assign run_d = (state_d == ICT_ST_RUN);
	assign end_d = run_d && (6'(k_d + ICT_T_ONE) == t_d);

	ict_bus_type u_bus_type
	(
		.k(k_d),
		.t(t_d),
		.pcw(pcw_d),
		.dpat(dpat_d),
		.nb(nb_d),
		.first_seq(fs_d),
		.icyc(icyc_w),
		.dcyc(dcyc_w)
	);

	// ==========================================================
	// Sequencer and plan registers
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			state_q <= ICT_ST_IDLE;
			k_q <= '0;
			t_q <= ICT_T_ONE;
			nb_q <= ICT_T_ONE;
			ilk_q <= '0;
			pcw_q <= 1'b0;
			fs_q <= 1'b0;
			spec_q <= 1'b0;
			dpat_q <= ICT_DP_IDLE;
		end
		else
		begin
			state_q <= state_d;
			k_q <= k_d;
			t_q <= t_d;
			nb_q <= nb_d;
			ilk_q <= ilk_d;
			pcw_q <= pcw_d;
			fs_q <= fs_d;
			spec_q <= spec_d;
			dpat_q <= dpat_d;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			I_CYC <= ICT_INT;
			D_CYC <= ICT_INT;
			ISSUE_READY <= 1'b1;
			INSTR_END <= 1'b0;
			INTERLOCK <= 1'b0;
			DATA_SPECULATIVE_FLAG <= 1'b0;
		end
		else
		begin
			I_CYC <= run_d ? icyc_w : ICT_INT;
			D_CYC <= run_d ? dcyc_w : ICT_INT;
			ISSUE_READY <= !run_d || end_d;
			INSTR_END <= end_d;
			INTERLOCK <= run_d && (ilk_d != '0) && (k_d >= 6'(t_d - ilk_d));
			DATA_SPECULATIVE_FLAG <= run_d && spec_d;
		end
	end

	// ==========================================================
	// Checks
	a_idle_bus_int:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		state_q == ICT_ST_IDLE |-> I_CYC == ICT_INT && D_CYC == ICT_INT)
	else $error("idle cycle not internal on both buses");

	a_dataop_one_cycle:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_DATAOP && !ISSUE_PC_DEST && !ISSUE_REG_SHIFT
		|=> I_CYC == ICT_SEQ && D_CYC == ICT_INT && INSTR_END)
	else $error("plain data op not one S cycle");

	a_regshift_two_cycle:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_DATAOP && !ISSUE_PC_DEST && ISSUE_REG_SHIFT
		|=> I_CYC == ICT_SEQ && !INSTR_END ##1 I_CYC == ICT_INT && INSTR_END)
	else $error("register shift op not S then I");

	a_pc_arith_seq:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_DATAOP && ISSUE_PC_DEST && ISSUE_ARITH && !ISSUE_SHIFTED && !ISSUE_REG_SHIFT
		|=> I_CYC == ICT_SEQ ##1 I_CYC == ICT_NSEQ ##1 I_CYC == ICT_SEQ && D_CYC == ICT_INT && INSTR_END)
	else $error("arithmetic PC write not 2S+1N in three cycles");

	a_load_plain_one:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_WORD_LOAD && !ISSUE_PC_DEST && !ISSUE_SHIFTED && !dep
		|=> D_CYC == ICT_NSEQ && INSTR_END)
	else $error("plain word load not one N cycle");

	a_load_use_stall:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_WORD_LOAD && !ISSUE_PC_DEST && !ISSUE_SHIFTED && !ISSUE_NARROW && dep
		|=> D_CYC == ICT_NSEQ && !INTERLOCK ##1 D_CYC == ICT_INT && INTERLOCK && INSTR_END)
	else $error("load-use interlock not one internal cycle");

	a_narrow_use_stall:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_WORD_LOAD && !ISSUE_PC_DEST && ISSUE_NARROW && dep
		|=> !INSTR_END [*2] ##1 INSTR_END && INTERLOCK)
	else $error("narrow load-use not three cycles");

	a_load_pc_five:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_WORD_LOAD && ISSUE_PC_DEST && !ISSUE_SHIFTED
		|=> D_CYC == ICT_NSEQ ##1 (!INSTR_END && D_CYC == ICT_INT) [*3] ##1 INSTR_END)
	else $error("load into PC not five cycles");

	a_swap_use_seq:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_SWAP && dep
		|=> D_CYC == ICT_NSEQ ##1 D_CYC == ICT_NSEQ ##1 D_CYC == ICT_INT && INSTR_END)
	else $error("dependent swap not 2N+1I");

	a_branch_three:
	assert property (@(posedge CLK) disable iff (SYS_RST)
		acc && ISSUE_CLASS == ICT_CL_BRANCH
		|=> I_CYC == ICT_SEQ ##1 I_CYC == ICT_NSEQ ##1 I_CYC == ICT_SEQ && D_CYC == ICT_INT && INSTR_END)
	else $error("branch not 2S+1N in three cycles");

endmodule

// ### sim/ict_mem_model.sv
// Memory-side model counting fetches, data accesses and coprocessor cycles
`timescale 1ns/1ps
module ict_mem_model
	import ict_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus cycle classes
	input wire ict_cyc_t i_cyc,
	input wire ict_cyc_t d_cyc,
	// Access counts
	output logic [15:0] i_acc,
	output logic [15:0] d_acc,
	output logic [15:0] c_cnt
);
	// ==========================================================
	// Fetches and data accesses served, internal cycles skipped
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			i_acc <= 16'h0000;
			d_acc <= 16'h0000;
			c_cnt <= 16'h0000;
		end
		else
		begin
			i_acc <= i_acc + 16'((i_cyc == ICT_NSEQ) || (i_cyc == ICT_SEQ));
			d_acc <= d_acc + 16'((d_cyc == ICT_NSEQ) || (d_cyc == ICT_SEQ));
			c_cnt <= c_cnt + 16'((i_cyc == ICT_COPROC) || (d_cyc == ICT_COPROC));
		end
	end
endmodule

// ### sim/instruction_cycle_timing_bench.sv
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
module instruction_cycle_timing_bench
	import ict_pkg::*;
;
	logic clk, rst, iv, pcd, rs, sh, ar, nar, nv, rdy, iend, ilk, spec;
	ict_class_t cls;
	logic [4:0] nr;
	logic [3:0] ld, cw, sa, sb, sc;
	logic [2:0] se;
	ict_cyc_t icyc, dcyc;
	logic [15:0] i_acc, d_acc, c_cnt;
	int n_errors, cmp_count, exp_i, exp_d;

	ict_timing ict_timing_inst
	(
		.CLK(clk), .SYS_RST(rst), .ISSUE_VALID(iv), .ISSUE_CLASS(cls), .ISSUE_PC_DEST(pcd),
		.ISSUE_REG_SHIFT(rs), .ISSUE_SHIFTED(sh), .ISSUE_ARITH(ar), .ISSUE_NARROW(nar), .ISSUE_NREGS(nr),
		.ISSUE_LOAD_DEST(ld), .COPROC_WAIT(cw), .NEXT_VALID(nv), .NEXT_SRC_A(sa), .NEXT_SRC_B(sb),
		.NEXT_SRC_C(sc), .NEXT_SRC_EN(se), .ISSUE_READY(rdy), .INSTR_END(iend), .INTERLOCK(ilk),
		.DATA_SPECULATIVE_FLAG(spec), .I_CYC(icyc), .D_CYC(dcyc)
	);
	ict_mem_model ict_mem_model_inst
	(
		.clk(clk), .rst(rst), .i_cyc(icyc), .d_cyc(dcyc), .i_acc(i_acc), .d_acc(d_acc), .c_cnt(c_cnt)
	);

	// ==========================================================
	// Expected timing
	function automatic logic [5:0] calc_t(ict_class_t c, logic p, r, s, a, w, logic [4:0] n, logic d, logic [3:0] b);
		case (c)
			ICT_CL_DATAOP: return p ? ((a && !s && !r) ? 6'h03 : 6'h04) : (r ? 6'h02 : 6'h01);
			ICT_CL_WORD_LOAD: return p ? (s ? 6'h06 : 6'h05) : (w && d) ? 6'h03 : 6'(s) + 6'(d) + 6'h01;
			ICT_CL_DWORD_LOAD, ICT_CL_SWAP: return 6'h02 + 6'(d);
			ICT_CL_WORD_STORE: return 6'h01 + 6'(s);
			ICT_CL_DWORD_STORE: return 6'h02;
			ICT_CL_MULTI_LOAD: return p ? 6'(n) + 6'h04 : (n == 5'h01) ? 6'h02 : 6'(n) + 6'(d);
			ICT_CL_MULTI_STORE: return (n == 5'h01) ? 6'h02 : 6'(n);
			ICT_CL_BRANCH, ICT_CL_SOFT_INT, ICT_CL_UNDEF: return 6'h03;
			ICT_CL_COPROC_DP: return 6'(b) + 6'h01;
			default: return 6'h01;
		endcase
	endfunction

	function automatic ict_cyc_t exp_icyc(logic pw, logic [5:0] k, logic [5:0] t);
		if (k == 6'h00)
			return ICT_SEQ;
		if (pw && k == t - 6'h02)
			return ICT_NSEQ;
		if (pw && k == t - 6'h01)
			return ICT_SEQ;
		return ICT_INT;
	endfunction

	function automatic ict_cyc_t exp_dcyc(ict_class_t c, logic p, logic [5:0] k, logic [4:0] n);
		logic [5:0] nb;
		case (c)
			ICT_CL_WORD_LOAD, ICT_CL_WORD_STORE: nb = 6'h01;
			ICT_CL_DWORD_LOAD, ICT_CL_DWORD_STORE, ICT_CL_SWAP: nb = 6'h02;
			ICT_CL_MULTI_LOAD, ICT_CL_MULTI_STORE: nb = 6'(n);
			default: nb = 6'h00;
		endcase
		if (k >= nb)
			return ICT_INT;
		if (c == ICT_CL_SWAP || k == 6'h00)
			return (c == ICT_CL_MULTI_LOAD && n == 5'h01 && !p) ? ICT_SEQ : ICT_NSEQ;
		return ICT_SEQ;
	endfunction

	// ==========================================================
	// Reporting
	task automatic final_report();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic err(string m);
		$display("ERROR %0t %s", $time, m);
		n_errors++;
	endtask

	task automatic chk(ict_cyc_t ei, ict_cyc_t ed, logic e, logic il, logic sp, int k);
		cmp_count++;
		exp_i += int'(ei == ICT_NSEQ || ei == ICT_SEQ);
		exp_d += int'(ed == ICT_NSEQ || ed == ICT_SEQ);
		if ({icyc, dcyc, iend, rdy, ilk, spec} !== {ei, ed, e, e, il, sp})
			err($sformatf("cycle %0d class %0d got %b", k, cls, {icyc, dcyc, iend, rdy, ilk, spec}));
	endtask

	// ==========================================================
	// Issue driving
	task automatic drive(ict_class_t c, logic p, r, s, a, w, logic [4:0] n, logic d, logic [3:0] b);
		logic [3:0] g;
		int q;
		g = 4'($urandom);
		q = $urandom % 3;
		iv <= 1'b1;
		cls <= c;
		pcd <= p;
		rs <= r;
		sh <= s;
		ar <= a;
		nar <= w;
		nr <= n;
		cw <= b;
		ld <= g;
		nv <= d | 1'($urandom);
		sa <= (d && q == 0) ? g : g ^ 4'h1;
		sb <= (d && q == 1) ? g : g ^ 4'h2;
		sc <= (d && q == 2) ? g : g ^ 4'h3;
		se <= 3'($urandom) | (d ? 3'(1 << q) : 3'h0);
	endtask

	task automatic take();
		int j;
		j = 0;
		do
		begin
			@(negedge clk);
			j++;
		end
		while (rdy !== 1'b1 && j < 40);
		if (rdy !== 1'b1)
		begin
			err("offer never taken");
			final_report();
		end
		@(posedge clk);
	endtask

	task automatic run(ict_class_t c, logic p, r, s, a, w, logic [4:0] n, logic d, logic [3:0] b);
		logic de;
		logic pw;
		logic [5:0] t;
		logic [5:0] il;
		logic [5:0] k6;
		de = d && !p && (c inside {ICT_CL_WORD_LOAD, ICT_CL_DWORD_LOAD, ICT_CL_MULTI_LOAD, ICT_CL_SWAP});
		pw = (p && c inside {ICT_CL_DATAOP, ICT_CL_WORD_LOAD, ICT_CL_MULTI_LOAD}) || c inside {[ICT_CL_BRANCH:ICT_CL_UNDEF]};
		t = calc_t(c, p, r, s, a, w, n, de, b);
		il = !de ? 6'h00 : (w && c == ICT_CL_WORD_LOAD) ? 6'h02 : 6'h01;
		@(posedge clk);
		drive(c, p, r, s, a, w, n, d, b);
		take();
		iv <= 1'b0;
		for (int k = 0; k < t; k++)
		begin
			@(negedge clk);
			k6 = 6'(k);
			chk(exp_icyc(pw, k6, t), exp_dcyc(c, p, k6, n), k6 == t - 1, k6 >= t - il, c == ICT_CL_PRELOAD, k);
		end
	endtask

	// ==========================================================
	// Clock and main sequence
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		ict_class_t c;
		logic [4:0] n;
		logic d;
		void'($urandom(32'hFC8B5BE6));
		rst = 1'b1;
		{iv, pcd, rs, sh, ar, nar, nv} <= 7'h00;
		cls <= ICT_CL_DATAOP;
		nr <= 5'h01;
		{ld, cw, sa, sb, sc} <= 20'h00000;
		se <= 3'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		cmp_count++;
		if ({icyc, dcyc, iend, rdy, ilk, spec} !== {ICT_INT, ICT_INT, 4'h4})
			err("outputs not idle after reset");
		run(ICT_CL_DATAOP, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_LZ_COUNT, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DATAOP, 0, 1, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DATAOP, 1, 0, 0, 1, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DATAOP, 1, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DATAOP, 1, 0, 1, 1, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_WORD_LOAD, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_WORD_LOAD, 0, 0, 0, 0, 0, 5'h01, 1, 4'h0);
		run(ICT_CL_WORD_LOAD, 0, 0, 1, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_WORD_LOAD, 0, 0, 1, 0, 0, 5'h01, 1, 4'h0);
		run(ICT_CL_WORD_LOAD, 0, 0, 0, 0, 1, 5'h01, 1, 4'h0);
		run(ICT_CL_WORD_LOAD, 1, 0, 0, 0, 0, 5'h01, 1, 4'h0);
		run(ICT_CL_WORD_LOAD, 1, 0, 1, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DWORD_LOAD, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DWORD_LOAD, 0, 0, 0, 0, 0, 5'h01, 1, 4'h0);
		run(ICT_CL_MULTI_LOAD, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_MULTI_LOAD, 0, 0, 0, 0, 0, 5'h10, 1, 4'h0);
		run(ICT_CL_MULTI_LOAD, 0, 0, 0, 0, 0, 5'h02, 0, 4'h0);
		run(ICT_CL_MULTI_LOAD, 1, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_MULTI_LOAD, 1, 0, 0, 0, 0, 5'h10, 1, 4'h0);
		run(ICT_CL_SWAP, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_SWAP, 0, 0, 0, 0, 0, 5'h01, 1, 4'h0);
		for (int x = 10; x < 13; x++)
			run(ict_class_t'(x), 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_WORD_STORE, 0, 0, 0, 0, 0, 5'h01, 1, 4'h0);
		run(ICT_CL_WORD_STORE, 0, 0, 1, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_DWORD_STORE, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_MULTI_STORE, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_MULTI_STORE, 0, 0, 0, 0, 0, 5'h10, 0, 4'h0);
		run(ICT_CL_PRELOAD, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		run(ICT_CL_COPROC_DP, 0, 0, 0, 0, 0, 5'h01, 0, 4'hF);
		// Held offer refused during a branch, then taken back to back
		@(posedge clk);
		drive(ICT_CL_BRANCH, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		take();
		drive(ICT_CL_DATAOP, 0, 0, 0, 0, 0, 5'h01, 0, 4'h0);
		for (int k = 0; k < 4; k++)
		begin
			@(negedge clk);
			chk(k == 1 ? ICT_NSEQ : ICT_SEQ, ICT_INT, k >= 2, 0, 0, k);
			if (k == 2)
			begin
				@(posedge clk);
				iv <= 1'b0;
			end
		end
		// Reset dropped into a long multi-register load
		@(posedge clk);
		drive(ICT_CL_MULTI_LOAD, 0, 0, 0, 0, 0, 5'h10, 0, 4'h0);
		take();
		iv <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		exp_i = 0;
		exp_d = 0;
		for (int k = 0; k < 2; k++)
		begin
			@(negedge clk);
			cmp_count++;
			if ({icyc, dcyc, iend, rdy, ilk, spec} !== {ICT_INT, ICT_INT, 4'h4})
				err("outputs not idle after mid-run reset");
		end
		// Random mix, illegal class codes included
		for (int x = 0; x < 80; x++)
		begin
			c = ict_class_t'($urandom % 16);
			n = 5'($urandom % 16 + 1);
			d = 1'($urandom) && !(c == ICT_CL_MULTI_LOAD && n == 5'h01);
			run(c, 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), n, d, 4'($urandom));
		end
		repeat (2) @(negedge clk);
		cmp_count++;
		if (i_acc !== 16'(exp_i) || d_acc !== 16'(exp_d) || c_cnt !== 16'h0000)
			err("memory side access count mismatch");
		final_report();
	end
endmodule
